// >>> pkg/lsu_params.svh
// Purpose: Constants for the load/store execution unit
// Assumes: 16-bit words, byte-addressed memory, 16 general registers
// Notes: Operation codes are local to this unit, not instruction encodings
`ifndef LSU_PARAMS_SVH
`define LSU_PARAMS_SVH
`define LSU_MAJOR_PTR_STORE 4'h5
`define LSU_SUB_STORE 4'h6
`define LSU_SUB_STORE_INC 4'h8
`define LSU_SUB_STORE_DEC 4'ha
`define LSU_STACK_REG 4'hf
`define LSU_MULTI_REG 4'h0
`define LSU_WORD_STEP 16'h0002
`define LSU_PC_AHEAD 16'h0002
`define LSU_BYTE_MSB 7
`define LSU_WORD_MSB 15
`define LSU_FLAGS_RESET 4'h0
`endif

// >>> pkg/lsu_pkg.sv
// Purpose: Types for the load/store execution unit
// Assumes: Included together with lsu_params.svh
// Notes: Operation select is decoded upstream into lsu_op_e
package lsu_pkg;
	typedef enum logic [3:0] {
		OP_NONE,
		OP_LOAD_WORD,
		OP_LOAD_BYTE,
		OP_LOAD_ADDR,
		OP_STORE_PTR,
		OP_STORE_WORD,
		OP_STORE_BYTE,
		OP_LOAD_DOUBLE,
		OP_STORE_DOUBLE,
		OP_POP,
		OP_PUSH,
		OP_LOAD_MULTI,
		OP_STORE_MULTI
	} lsu_op_e;
	typedef logic [15:0] word_t;
	typedef logic [3:0] reg_idx_t;
endpackage : lsu_pkg

// >>> hdl/lsu_regfile.sv
// Purpose: Sixteen-word general register file with two read ports
// Assumes: One write port, registered read data
// Notes: Read data show the value before a write in the same cycle
`timescale 1ns/1ps
`default_nettype none
module lsu_regfile (
	input wire logic clk,
	input wire logic rst,
	input wire logic we,
	input wire logic [3:0] waddr,
	input wire logic [15:0] wdata,
	input wire logic [3:0] raddr_a,
	input wire logic [3:0] raddr_b,
	output logic [15:0] rdata_a,
	output logic [15:0] rdata_b
);
	logic [15:0] mem_q [0:15];
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_reg
			always_ff @(posedge clk) begin
				if (rst)
					mem_q[gi] <= 16'h0000;
				else if (we && waddr == 4'(gi))
					mem_q[gi] <= wdata;
			end
		end
	endgenerate
	always_ff @(posedge clk) begin
		rdata_a <= mem_q[raddr_a];
		rdata_b <= mem_q[raddr_b];
	end
endmodule : lsu_regfile
`default_nettype wire

// >>> hdl/load_store_execution_unit.sv
// Purpose: Executes the load and store instruction group
// Assumes: Decode supplies op, register fields, count, displacement, address
// Notes: One memory byte lane per request; host bus replies with MEM_ACK
// Contract
// - Word load fills the target from two bytes at the effective address
// - Word load: nonzero if word nonzero, most is bit 15, V and L kept
// - Byte load writes the low byte only, upper byte kept
// - Byte load: nonzero from byte, most is bit 7, V and L kept
// - Load-address writes pc plus displacement, no memory access
// - Load-address: nonzero clear only for zero displacement, others kept
// - Pointer store writes source word at the pointer register address
// - Store-increment writes the word then adds two to the pointer
// - Store-decrement writes the word then subtracts two from the pointer
// - Word store: nonzero from source, most is bit 15, V and L kept
// - Address-form store writes two bytes; index field zero still indexes
// - Byte store writes low byte; flags from that byte and bit 7
// - Double load fills a pair from four bytes; nonzero from all bytes, most is bit 15 of the first word
// - Double store writes a pair to four bytes; nonzero from both words, most is bit 15 of the first word
// - Pop lowers r15 by two then loads, descending registers, no flags
// - Push stores at r15, adds two, ascending registers, no flags
// - Load-multiple is pop with r0 as pointer
// - Store-multiple is push with r0 as pointer
// - Program counter operand reads as instruction address plus two
`timescale 1ns/1ps
`default_nettype none
`include "lsu_params.svh"
module load_store_execution_unit (
	input wire logic CLK,
	input wire logic RST,
	input wire logic START,
	input wire lsu_pkg::lsu_op_e OP,
	input wire logic [3:0] SUBCODE,
	input wire lsu_pkg::reg_idx_t TARGET_REGISTER,
	input wire lsu_pkg::reg_idx_t POINTER_REGISTER,
	input wire logic [4:0] COUNT,
	input wire lsu_pkg::word_t DISPLACEMENT,
	input wire lsu_pkg::word_t EFFECTIVE_ADDRESS,
	input wire lsu_pkg::word_t INSTR_ADDR,
	input wire logic [3:0] FLAGS_IN,
	input wire logic MEM_ACK,
	input wire logic [7:0] MEM_RDATA,
	output logic BUSY,
	output logic DONE,
	output logic [3:0] FLAGS,
	output logic MEM_REQ,
	output logic MEM_WE,
	output logic [15:0] MEM_ADDR,
	output logic [7:0] MEM_WDATA,
	output logic [15:0] DBG_TARGET
);
	import lsu_pkg::*;
	// FLAGS bit order: 3 nonzero, 2 overflow, 1 link, 0 most
	typedef enum logic [2:0] {
		ST_IDLE, ST_READ, ST_XFER, ST_WBACK, ST_PTR, ST_DONE
	} state_e;
	state_e state_q, state_d;
	lsu_op_e op_q;
	logic [3:0] sub_q;
	reg_idx_t tgt_q, ptr_q, cur_q;
	logic [4:0] cnt_q;
	word_t addr_q, ptrval_q, data_q, data2_q, displacement_q, pc_q;
	logic [1:0] byte_q;
	logic [3:0] flags_q;
	logic nz_acc_q;
	logic req_q, we_q, busy_q, done_q, refetch_q;
	logic [7:0] wbyte_q;
	word_t dbg_q;
	logic rf_we;
	reg_idx_t rf_waddr, rf_ra, rf_rb;
	word_t rf_wdata, rd_a, rd_b;
	lsu_regfile u_rf (
		.clk(CLK),
		.rst(RST),
		.we(rf_we),
		.waddr(rf_waddr),
		.wdata(rf_wdata),
		.raddr_a(rf_ra),
		.raddr_b(rf_rb),
		.rdata_a(rd_a),
		.rdata_b(rd_b)
	);
	// Operation classes
	wire is_double = (op_q == OP_LOAD_DOUBLE) || (op_q == OP_STORE_DOUBLE);
	wire is_multi = (op_q == OP_POP) || (op_q == OP_PUSH) ||
		(op_q == OP_LOAD_MULTI) || (op_q == OP_STORE_MULTI);
	wire is_desc = (op_q == OP_POP) || (op_q == OP_LOAD_MULTI);
	wire is_load = (op_q == OP_LOAD_WORD) || (op_q == OP_LOAD_BYTE) ||
		(op_q == OP_LOAD_DOUBLE) || is_desc;
	wire is_byte = (op_q == OP_LOAD_BYTE) || (op_q == OP_STORE_BYTE);
	wire ptr_store_ok = (sub_q == `LSU_SUB_STORE) ||
		(sub_q == `LSU_SUB_STORE_INC) || (sub_q == `LSU_SUB_STORE_DEC);
	// Stack ops use r15, multiple ops use r0
	wire [3:0] multi_ptr = ((op_q == OP_POP) || (op_q == OP_PUSH)) ?
		`LSU_STACK_REG : `LSU_MULTI_REG;
	wire [1:0] last_byte = is_byte ? 2'd0 : (is_double ? 2'd3 : 2'd1);
	wire word_hi = byte_q[0];
	// Big-endian: lower address holds the high byte
	wire [15:0] cur_word = (is_double && byte_q[1]) ? data2_q : data_q;
	// Outputs are registered, so an ack must already set up the next byte
	wire [1:0] byte_nx = (state_q == ST_XFER && MEM_ACK) ?
		byte_q + 2'd1 : byte_q;
	wire [15:0] nx_word = (is_double && byte_nx[1]) ? data2_q : data_q;
	wire [7:0] store_byte = is_byte ? data_q[7:0] :
		(byte_nx[0] ? nx_word[7:0] : nx_word[15:8]);
	wire [15:0] ptr_inc = ptrval_q + `LSU_WORD_STEP;
	wire [15:0] ptr_dec = ptrval_q - `LSU_WORD_STEP;
	wire [15:0] pc_operand = INSTR_ADDR + `LSU_PC_AHEAD;
	wire [15:0] la_result = pc_q + displacement_q;
	wire xfer_last = MEM_ACK && (byte_q == last_byte);
	wire [7:0] rbyte = MEM_RDATA;
	wire [15:0] rd_word = word_hi ? {cur_word[15:8], rbyte} : {rbyte, 8'h00};
	wire [3:0] idx_next = is_desc ? cur_q - 4'd1 : cur_q + 4'd1;
	// Flag outcomes, V and L always carried through
	wire [3:0] f_word_ld = {|rd_word, flags_q[2:1], rd_word[`LSU_WORD_MSB]};
	wire [3:0] f_byte_ld = {|rbyte, flags_q[2:1], rbyte[`LSU_BYTE_MSB]};
	wire [3:0] f_dbl_ld = {nz_acc_q | (|rbyte), flags_q[2:1], data_q[15]};
	wire [3:0] f_la = {|displacement_q, flags_q[2:1], flags_q[0]};
	wire [3:0] f_word_st = {|data_q, flags_q[2:1],
		data_q[`LSU_WORD_MSB]};
	wire [3:0] f_byte_st = {|data_q[7:0], flags_q[2:1],
		data_q[`LSU_BYTE_MSB]};
	wire [3:0] f_dbl_st = {(|data_q) | (|data2_q), flags_q[2:1],
		data_q[`LSU_WORD_MSB]};
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: if (START) state_d = ST_READ;
			ST_READ: begin
				if (op_q == OP_LOAD_ADDR)
					state_d = ST_DONE;
				else if (op_q == OP_NONE)
					state_d = ST_DONE;
				else if (op_q == OP_STORE_PTR && !ptr_store_ok)
					state_d = ST_DONE;
				else if (is_multi && cnt_q == 5'd0)
					state_d = ST_DONE;
				else
					state_d = ST_XFER;
			end
			ST_XFER: if (xfer_last) state_d = ST_WBACK;
			ST_WBACK: state_d = ST_PTR;
			ST_PTR: begin
				if (is_multi && cnt_q != 5'd0)
					state_d = ST_XFER;
				else
					state_d = ST_DONE;
			end
			ST_DONE: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end
	// Register file ports
	// Look ahead in PTR so the next push source is read in time
	assign rf_ra = (state_q == ST_IDLE) ? TARGET_REGISTER :
		(state_q == ST_PTR) ? idx_next : cur_q;
	assign rf_rb = (state_q == ST_IDLE) ?
		(OP == OP_STORE_PTR ? POINTER_REGISTER :
		(OP == OP_POP || OP == OP_PUSH) ? `LSU_STACK_REG :
		(OP == OP_LOAD_MULTI || OP == OP_STORE_MULTI) ? `LSU_MULTI_REG :
		TARGET_REGISTER + 4'd1) : ptr_q;
	wire wb_load = (state_q == ST_WBACK) && is_load;
	wire wb_la = (state_q == ST_READ) && (op_q == OP_LOAD_ADDR);
	wire wb_ptr = (state_q == ST_PTR) && (is_multi ||
		(op_q == OP_STORE_PTR && sub_q != `LSU_SUB_STORE));
	wire wb_dbl2 = (state_q == ST_PTR) && (op_q == OP_LOAD_DOUBLE);
	assign rf_we = wb_load || wb_la || wb_ptr || wb_dbl2;
	assign rf_waddr = wb_dbl2 ? tgt_q + 4'd1 :
		(wb_ptr ? ptr_q : (wb_la ? tgt_q : cur_q));
	wire [15:0] ptr_new = (is_multi && !is_desc) ||
		(sub_q == `LSU_SUB_STORE_INC) ? ptr_inc : ptr_dec;
	// Multi pop writes the already-lowered pointer it used to load
	assign rf_wdata = wb_dbl2 ? data2_q : wb_ptr ?
		(is_desc ? ptrval_q : ptr_new) : wb_la ? la_result :
		(op_q == OP_LOAD_BYTE ? {rd_a[15:8], data_q[7:0]} :
		data_q);
	always_ff @(posedge CLK) begin
		if (RST)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end
	always_ff @(posedge CLK) begin
		if (RST) begin
			op_q <= OP_NONE;
			sub_q <= 4'h0;
			tgt_q <= 4'h0;
			ptr_q <= 4'h0;
			cur_q <= 4'h0;
			cnt_q <= 5'd0;
			displacement_q <= 16'h0000;
			pc_q <= 16'h0000;
			addr_q <= 16'h0000;
		end else if (state_q == ST_IDLE && START) begin
			op_q <= OP;
			sub_q <= SUBCODE;
			tgt_q <= TARGET_REGISTER;
			cur_q <= TARGET_REGISTER;
			cnt_q <= COUNT;
			displacement_q <= DISPLACEMENT;
			pc_q <= pc_operand;
			// Address-form ops take the formed address as is
			addr_q <= EFFECTIVE_ADDRESS;
			ptr_q <= (OP == OP_STORE_PTR) ? POINTER_REGISTER : 4'h0;
		end else if (state_q == ST_READ && is_multi) begin
			ptr_q <= multi_ptr;
		end else if (state_q == ST_WBACK && is_multi) begin
			cnt_q <= cnt_q - 5'd1;
		end else if (state_q == ST_PTR && is_multi) begin
			cur_q <= idx_next;
		end
	end
	// Pointer tracking and byte sequencing
	always_ff @(posedge CLK) begin
		if (RST) begin
			ptrval_q <= 16'h0000;
			byte_q <= 2'd0;
		end else if (state_q == ST_READ) begin
			byte_q <= 2'd0;
			ptrval_q <= (is_desc ? rd_b - `LSU_WORD_STEP : rd_b);
		end else if (state_q == ST_XFER && MEM_ACK && !xfer_last) begin
			byte_q <= byte_q + 2'd1;
		end else if (state_q == ST_PTR) begin
			byte_q <= 2'd0;
			ptrval_q <= is_desc ? ptr_dec : ptr_new;
		end
	end
	// Data capture: stores latch source, loads assemble bytes
	always_ff @(posedge CLK) begin
		if (RST) begin
			data_q <= 16'h0000;
			data2_q <= 16'h0000;
			nz_acc_q <= 1'b0;
		end else if (state_q == ST_READ || (state_q == ST_PTR && is_multi)) begin
			data_q <= (state_q == ST_READ) ? rd_a : 16'h0000;
			data2_q <= rd_b;
			nz_acc_q <= 1'b0;
		end else if (refetch_q) begin
			data_q <= rd_a;
		end else if (state_q == ST_WBACK && is_multi && !is_load) begin
			data_q <= data_q;
		end else if (state_q == ST_XFER && MEM_ACK && is_load) begin
			nz_acc_q <= nz_acc_q | (|rbyte);
			if (is_byte)
				data_q <= {8'h00, rbyte};
			else if (is_double && byte_q[1])
				data2_q <= rd_word;
			else
				data_q <= rd_word;
		end
	end
	// Multi stores idle one cycle while the looked-ahead word lands in data_q
	always_ff @(posedge CLK) begin
		if (RST)
			refetch_q <= 1'b0;
		else
			refetch_q <= (state_q == ST_PTR) && is_multi && !is_load;
	end
	// Memory request generation
	wire [15:0] base_addr = (is_multi || op_q == OP_STORE_PTR) ?
		ptrval_q : addr_q;
	always_ff @(posedge CLK) begin
		if (RST) begin
			req_q <= 1'b0;
			we_q <= 1'b0;
			wbyte_q <= 8'h00;
		end else if (state_q == ST_XFER && !xfer_last && !refetch_q) begin
			req_q <= 1'b1;
			we_q <= !is_load;
			wbyte_q <= store_byte;
		end else begin
			req_q <= 1'b0;
			we_q <= 1'b0;
		end
	end
	logic [15:0] maddr_q;
	always_ff @(posedge CLK) begin
		if (RST)
			maddr_q <= 16'h0000;
		else
			maddr_q <= base_addr + {14'h0000, byte_nx};
	end
	// Flag update at completion; multi ops leave flags untouched
	always_ff @(posedge CLK) begin
		if (RST)
			flags_q <= `LSU_FLAGS_RESET;
		else if (state_q == ST_IDLE && START)
			flags_q <= FLAGS_IN;
		else if (wb_la)
			flags_q <= f_la;
		else if (state_q == ST_XFER && xfer_last) begin
			case (op_q)
				OP_LOAD_WORD: flags_q <= f_word_ld;
				OP_LOAD_BYTE: flags_q <= f_byte_ld;
				OP_LOAD_DOUBLE: flags_q <= f_dbl_ld;
				OP_STORE_PTR: flags_q <= f_word_st;
				OP_STORE_WORD: flags_q <= f_word_st;
				OP_STORE_BYTE: flags_q <= f_byte_st;
				OP_STORE_DOUBLE: flags_q <= f_dbl_st;
				default: flags_q <= flags_q;
			endcase
		end
	end
	always_ff @(posedge CLK) begin
		if (RST) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			dbg_q <= 16'h0000;
		end else begin
			busy_q <= (state_d != ST_IDLE);
			done_q <= (state_q == ST_DONE);
			dbg_q <= rf_we ? rf_wdata : dbg_q;
		end
	end
	assign BUSY = busy_q;
	assign DONE = done_q;
	assign FLAGS = flags_q;
	assign MEM_REQ = req_q;
	assign MEM_WE = we_q;
	assign MEM_ADDR = maddr_q;
	assign MEM_WDATA = wbyte_q;
	assign DBG_TARGET = dbg_q;
endmodule : load_store_execution_unit
`default_nettype wire

// >>> tb/lsu_checker.sv
// Purpose: Port-level assertions for the load/store execution unit
// Assumes: Bench holds operation inputs steady until DONE
// Notes: Register contents are not visible here, only timing, addresses and flags
`timescale 1ns/1ps
`default_nettype none
module lsu_checker (
	input wire logic CLK,
	input wire logic RST,
	input wire logic START,
	input wire lsu_pkg::lsu_op_e OP,
	input wire logic [3:0] SUBCODE,
	input wire lsu_pkg::word_t DISPLACEMENT,
	input wire lsu_pkg::word_t EFFECTIVE_ADDRESS,
	input wire logic [3:0] FLAGS_IN,
	input wire logic MEM_ACK,
	input wire logic BUSY,
	input wire logic DONE,
	input wire logic [3:0] FLAGS,
	input wire logic MEM_REQ,
	input wire logic MEM_WE,
	input wire logic [15:0] MEM_ADDR,
	input wire logic [7:0] MEM_WDATA
);
	import lsu_pkg::*;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	wire take = START && !BUSY;
	wire word_op = OP == OP_LOAD_WORD || OP == OP_STORE_WORD;
	a_done_pulse: assert property (DONE |=> !DONE)
		else $error("done pulse too long");
	a_req_hold: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ &&
		$stable(MEM_ADDR) && $stable(MEM_WE) && $stable(MEM_WDATA))
		else $error("request changed before ack");
	a_la_time: assert property (take && OP == OP_LOAD_ADDR |-> ##3
		(DONE && FLAGS[3] == (DISPLACEMENT != 16'h0000) &&
		FLAGS[2:0] == FLAGS_IN[2:0]))
		else $error("load address timing or flags wrong");
	a_la_quiet: assert property (
		take && OP == OP_LOAD_ADDR |=> !MEM_REQ [*3])
		else $error("load address touched memory");
	a_bad_sub: assert property (take && OP == OP_STORE_PTR &&
		!(SUBCODE inside {4'h6, 4'h8, 4'ha}) |=> !MEM_REQ [*3])
		else $error("bad subcode accessed memory");
	a_ea_first: assert property (take && word_op |-> ##[1:4]
		(MEM_REQ && MEM_ADDR == EFFECTIVE_ADDRESS))
		else $error("first byte not at address");
	a_ea_next: assert property (MEM_REQ && MEM_ACK && word_op &&
		MEM_ADDR == EFFECTIVE_ADDRESS |-> ##[1:4]
		(MEM_REQ && MEM_ADDR == EFFECTIVE_ADDRESS + 16'h0001))
		else $error("second byte not at next address");
	a_byte_addr: assert property (MEM_REQ && OP == OP_STORE_BYTE |->
		MEM_WE && MEM_ADDR == EFFECTIVE_ADDRESS)
		else $error("byte store address wrong");
	a_stack_flags: assert property (
		DONE && OP inside {OP_POP,
		OP_PUSH, OP_LOAD_MULTI, OP_STORE_MULTI} |-> FLAGS == FLAGS_IN)
		else $error("stack operation changed flags");
	a_vl_kept: assert property (
		DONE && OP inside {OP_LOAD_WORD,
		OP_LOAD_BYTE, OP_STORE_WORD, OP_STORE_BYTE, OP_LOAD_DOUBLE,
		OP_STORE_DOUBLE} |-> FLAGS[2:1] == FLAGS_IN[2:1])
		else $error("overflow or link changed");
endmodule : lsu_checker
bind load_store_execution_unit lsu_checker u_lsu_checker (.CLK(CLK),
	.RST(RST), .START(START), .OP(OP), .SUBCODE(SUBCODE),
	.DISPLACEMENT(DISPLACEMENT), .EFFECTIVE_ADDRESS(EFFECTIVE_ADDRESS),
	.FLAGS_IN(FLAGS_IN), .MEM_ACK(MEM_ACK), .BUSY(BUSY), .DONE(DONE),
	.FLAGS(FLAGS), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
	.MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA));
`default_nettype wire

// >>> tb/lsu_mem_model.sv
// Purpose: Byte memory answering the unit's request handshake
// Assumes: Only the low eight address bits are decoded
// Notes: Acks after 0..2 idle cycles; read data toggle when not valid
`timescale 1ns/1ps
`default_nettype none
module lsu_mem_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic req,
	input wire logic we,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	output logic ack,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:255];
	logic [1:0] wait_q;
	// Plain always so the bench may preload the array
	always @(posedge clk) begin
		if (rst) begin
			ack <= 1'b0;
			wait_q <= 2'h0;
			rdata <= 8'h5a;
		end else if (req && !ack && wait_q == 2'h0) begin
			ack <= 1'b1;
			rdata <= mem[addr[7:0]];
			if (we)
				mem[addr[7:0]] <= wdata;
			wait_q <= 2'($urandom_range(2));
		end else begin
			ack <= 1'b0;
			rdata <= ~rdata;
			if (wait_q != 2'h0)
				wait_q <= wait_q - 2'h1;
		end
	end
endmodule : lsu_mem_model
`default_nettype wire

// >>> tb/load_store_execution_unit_test.sv
// Purpose: Self-checking bench for the load/store execution unit
// Assumes: Pointer register field fixed at r2, registers reset to zero
// Notes: Registers are seen through stores back to memory
`timescale 1ns/1ps
`default_nettype none
module load_store_execution_unit_test;
	import lsu_pkg::*;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic START = 1'b0;
	lsu_op_e OP = OP_NONE;
	logic [3:0] SUBCODE = 4'h0;
	reg_idx_t TARGET_REGISTER = 4'h0;
	logic [4:0] COUNT = 5'h00;
	word_t DISPLACEMENT = 16'h0000;
	word_t EFFECTIVE_ADDRESS = 16'h0000;
	word_t INSTR_ADDR = 16'h0000;
	logic [3:0] FLAGS_IN = 4'h0;
	reg_idx_t POINTER_REGISTER = 4'h2;
	logic MEM_ACK, BUSY, DONE, MEM_REQ, MEM_WE;
	logic [7:0] MEM_RDATA, MEM_WDATA;
	logic [3:0] FLAGS;
	word_t MEM_ADDR, DBG_TARGET;
	logic [21:0] expq [$];
	logic [21:0] e;
	int err_count = 0;
	int total_checks = 0;
	initial forever #50 CLK = ~CLK;
	load_store_execution_unit u_load_store_execution_unit (.CLK(CLK),
		.RST(RST), .START(START), .OP(OP), .SUBCODE(SUBCODE),
		.TARGET_REGISTER(TARGET_REGISTER),
		.POINTER_REGISTER(POINTER_REGISTER),
		.COUNT(COUNT), .DISPLACEMENT(DISPLACEMENT),
		.EFFECTIVE_ADDRESS(EFFECTIVE_ADDRESS), .INSTR_ADDR(INSTR_ADDR),
		.FLAGS_IN(FLAGS_IN), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA),
		.BUSY(BUSY), .DONE(DONE), .FLAGS(FLAGS), .MEM_REQ(MEM_REQ),
		.MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
		.DBG_TARGET(DBG_TARGET));
	lsu_mem_model u_lsu_mem_model (.clk(CLK), .rst(RST), .req(MEM_REQ),
		.we(MEM_WE), .addr(MEM_ADDR), .wdata(MEM_WDATA), .ack(MEM_ACK),
		.rdata(MEM_RDATA));
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude
	task cmp16(input word_t got, input word_t exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp16
	task cmp4(input logic [3:0] got, input logic [3:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp4
	task put(input logic [7:0] a, input word_t v);
		u_lsu_mem_model.mem[a] = v[15:8];
		u_lsu_mem_model.mem[a + 8'h01] = v[7:0];
	endtask : put
	task chk(input logic [7:0] a, input word_t v);
		cmp16({u_lsu_mem_model.mem[a], u_lsu_mem_model.mem[a + 8'h01]}, v);
	endtask : chk
	// Start one operation, queue its expected result, wait for DONE
	task go(input lsu_op_e op, input logic [3:0] sub, input reg_idx_t ra,
		input logic [4:0] cnt, input word_t ea, input word_t displacement,
		input logic ct, input logic cf, input word_t tgt,
		input logic n, input logic m);
		logic [3:0] fi;
		word_t ia;
		int i;
		fi = 4'($urandom);
		ia = 16'($urandom);
		if (op inside {OP_POP, OP_PUSH, OP_LOAD_MULTI, OP_STORE_MULTI})
			expq.push_back({cf, ct, tgt, fi});
		else if (op == OP_LOAD_ADDR)
			expq.push_back({cf, ct, ia + 16'h0002 + displacement, n, fi[2:0]});
		else
			expq.push_back({cf, ct, tgt, n, fi[2:1], m});
		OP <= op;
		SUBCODE <= sub;
		TARGET_REGISTER <= ra;
		COUNT <= cnt;
		EFFECTIVE_ADDRESS <= ea;
		DISPLACEMENT <= displacement;
		INSTR_ADDR <= ia;
		FLAGS_IN <= fi;
		START <= 1'b1;
		@(posedge CLK);
		START <= 1'b0;
		i = 0;
		do begin
			@(negedge CLK);
			i++;
		end while (DONE !== 1'b1 && i < 200);
		if (DONE !== 1'b1) begin
			err_count++;
			conclude();
		end else
			@(posedge CLK);
	endtask : go
	initial forever begin
		@(negedge CLK);
		if (DONE === 1'b1 && expq.size() > 0) begin
			e = expq.pop_front();
			if (e[21])
				cmp4(FLAGS, e[3:0]);
			@(negedge CLK);
			if (e[20])
				cmp16(DBG_TARGET, e[19:4]);
		end
	end
	initial begin
		void'($urandom(32'he3858150));
		put(8'h10, 16'h9234);
		put(8'h12, 16'h0040);
		put(8'h14, 16'h0000);
		put(8'h16, 16'h85ee);
		put(8'h52, 16'h11ee);
		repeat (5) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		go(OP_LOAD_WORD, 0, 1, 0, 16'h0010, 0, 1, 1, 16'h9234, 1, 1);
		go(OP_LOAD_WORD, 0, 2, 0, 16'h0012, 0, 1, 1, 16'h0040, 1, 0);
		go(OP_LOAD_WORD, 0, 3, 0, 16'h0014, 0, 1, 1, 16'h0000, 0, 0);
		go(OP_LOAD_BYTE, 0, 1, 0, 16'h0016, 0, 1, 1, 16'h9285, 1, 1);
		go(OP_LOAD_ADDR, 0, 4, 0, 0, 0, 1, 1, 0, 0, 0);
		go(OP_LOAD_ADDR, 0, 4, 0, 0, 16'($urandom) | 16'h0001,
			1, 1, 0, 1, 0);
		$display("loads done");
		go(OP_STORE_PTR, 4'h8, 1, 0, 0, 0, 0, 1, 0, 1, 1);
		go(OP_STORE_PTR, 4'h6, 3, 0, 0, 0, 0, 1, 0, 0, 0);
		go(OP_STORE_PTR, 4'ha, 1, 0, 0, 0, 0, 1, 0, 1, 1);
		go(OP_STORE_PTR, 4'h6, 3, 0, 0, 0, 0, 1, 0, 0, 0);
		go(OP_STORE_PTR, 4'h3, 1, 0, 0, 0, 0, 0, 0, 0, 0);
		chk(8'h40, 16'h0000);
		chk(8'h42, 16'h9285);
		go(OP_STORE_WORD, 0, 1, 0, 16'h0050, 0, 0, 1, 0, 1, 1);
		chk(8'h50, 16'h9285);
		go(OP_STORE_BYTE, 0, 1, 0, 16'h0052, 0, 0, 1, 0, 1, 1);
		chk(8'h52, 16'h85ee);
		go(OP_STORE_DOUBLE, 0, 1, 0, 16'h0060, 0, 0, 1, 0, 1, 1);
		chk(8'h60, 16'h9285);
		chk(8'h62, 16'h0040);
		go(OP_LOAD_DOUBLE, 0, 5, 0, 16'h0060, 0, 0, 1, 0, 1, 1);
		go(OP_STORE_DOUBLE, 0, 5, 0, 16'h0064, 0, 0, 1, 0, 1, 1);
		chk(8'h64, 16'h9285);
		chk(8'h66, 16'h0040);
		$display("stores done");
		go(OP_PUSH, 0, 5, 2, 0, 0, 0, 1, 0, 0, 0);
		chk(8'h00, 16'h9285);
		chk(8'h02, 16'h0040);
		go(OP_POP, 0, 8, 2, 0, 0, 0, 1, 0, 0, 0);
		go(OP_STORE_DOUBLE, 0, 7, 0, 16'h0068, 0, 0, 1, 0, 1, 1);
		chk(8'h68, 16'h9285);
		chk(8'h6a, 16'h0040);
		put(8'h00, 16'h0000);
		put(8'h02, 16'h0000);
		go(OP_STORE_MULTI, 0, 7, 2, 0, 0, 0, 1, 0, 0, 0);
		chk(8'h00, 16'h9285);
		chk(8'h02, 16'h0040);
		go(OP_LOAD_MULTI, 0, 10, 2, 0, 0, 0, 1, 0, 0, 0);
		go(OP_STORE_DOUBLE, 0, 9, 0, 16'h006c, 0, 0, 1, 0, 1, 1);
		chk(8'h6c, 16'h9285);
		chk(8'h6e, 16'h0040);
		$display("stack done");
		repeat (3) @(posedge CLK);
		conclude();
	end
endmodule : load_store_execution_unit_test
`default_nettype wire
